// >>> hdl/tcmpc_edge_det.sv
// edge detector for the channel input pin, sampled on the operation clock tick
// assumes the pin is already synchronous to clk_i
`timescale 1ns/100ps
module tcmpc_edge_det (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// sampling
	input  wire logic sample_i,
	input  wire logic pin_i,
	// edge pulses
	output logic      rise_o,
	output logic      fall_o
);

	logic now_ff;
	logic old_ff;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			now_ff <= 1'b0;
			old_ff <= 1'b0;
		end else if (sample_i) begin
			now_ff <= pin_i;
			old_ff <= now_ff;
		end
	end

	logic chk_ff;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chk_ff <= 1'b0;
		end else begin
			chk_ff <= sample_i;
		end
	end

	assign rise_o = chk_ff & now_ff & ~old_ff;
	assign fall_o = chk_ff & ~now_ff & old_ff;

endmodule

// >>> hdl/tcmpc_pkg.sv
// constants for the timer channel mode and pwm configuration block
// assumes one 50 MHz clock and an 8-bit register port with one-cycle read latency
// Overview of operation
// - operation clock select picks prescaled clock a at 0, b at 1
// - operation clock drives the edge detector; count clock follows count clock select
// - count clock select 0 counts operation clock, 1 counts valid pin edges
// - count clock steps the counter, the output and the interrupt logic
// - width split 0 gives a 16-bit timer, 1 an 8-bit timer
// - trigger source 000 starts on software trigger only
// - trigger source 001 uses the valid pin edge for start and capture
// - trigger source 010 uses both pin edges, one to start, one to capture
// - trigger source 100 starts a one-shot or pwm slave on master interrupt
// - trigger source 110 starts a capture-mode slave on master interrupt, valid pin edge captures
// - input edge field 00 fall, 01 rise, 10 and 11 both edges split
// - mode field 000 interval, 010 capture, 011 event, 100 one-count, 110 capture-one
// - interval mode serves interval, square wave, divider and pwm master
// - one-count mode serves delay, one-shot, two-input master and pwm slave
// - start bit 1 raises interrupt and toggles output at start in repeating modes
// - one-count start bit 0 ignores retrigger, 1 accepts it; no interrupt either way
// - capture-one-count raises no start interrupt and ignores retrigger while counting
// - pwm period is master period data plus one operation clocks
// - pwm duty is slave data over master period data plus one
// - master select 0 makes channel 2 slave or independent, 1 master
// - each prescaled clock is peripheral clock over two to the field value
package tcmpc_pkg;

	// register offsets
	localparam logic [3:0] OFS_PRESCALER_SELECT = 4'h0;
	localparam logic [3:0] OFS_CH0_DATA_LOW     = 4'h1;
	localparam logic [3:0] OFS_CH0_DATA_HIGH    = 4'h2;
	localparam logic [3:0] OFS_CH1_DATA_LOW     = 4'h3;
	localparam logic [3:0] OFS_CH1_DATA_HIGH    = 4'h4;
	localparam logic [3:0] OFS_CH1_MODE_LOW     = 4'h5;
	localparam logic [3:0] OFS_CH1_MODE_HIGH    = 4'h6;
	localparam logic [3:0] OFS_CH2_MODE_LOW     = 4'h7;
	localparam logic [3:0] OFS_CH2_MODE_HIGH    = 4'h8;
	localparam logic [3:0] OFS_CONTROL          = 4'h9;
	localparam logic [3:0] OFS_STATUS           = 4'ha;
	localparam logic [3:0] OFS_CH1_COUNT_LOW    = 4'hb;
	localparam logic [3:0] OFS_CH1_COUNT_HIGH   = 4'hc;

	// reset values
	localparam logic [7:0]  RST_PRESCALER = 8'h00;
	localparam logic [15:0] RST_DATA      = 16'h0000;
	localparam logic [7:0]  RST_MODE      = 8'h00;

	// writable bits of the mode registers, reserved bits read zero
	localparam logic [7:0] MASK_MODE_HIGH = 8'h9f;
	localparam logic [7:0] MASK_MODE_LOW  = 8'hcf;

	// field positions
	localparam int POS_OP_CLOCK_SELECT    = 7;
	localparam int POS_COUNT_CLOCK_SELECT = 4;
	localparam int POS_WIDTH_SPLIT        = 3;
	localparam int POS_MASTER_SELECT      = 3;
	localparam int POS_START_BEHAVIOR     = 0;
	localparam int POS_CTL_CH0_START      = 0;
	localparam int POS_CTL_CH0_STOP       = 1;
	localparam int POS_CTL_CH1_START      = 2;
	localparam int POS_CTL_CH1_STOP       = 3;

	// trigger source codes
	localparam logic [2:0] TRG_SOFTWARE   = 3'h0;
	localparam logic [2:0] TRG_PIN_EDGE   = 3'h1;
	localparam logic [2:0] TRG_BOTH_EDGES = 3'h2;
	localparam logic [2:0] TRG_MASTER_PWM = 3'h4;
	localparam logic [2:0] TRG_MASTER_TWO = 3'h6;

	// operating mode codes
	localparam logic [2:0] MODE_INTERVAL = 3'h0;
	localparam logic [2:0] MODE_CAPTURE  = 3'h2;
	localparam logic [2:0] MODE_EVENT    = 3'h3;
	localparam logic [2:0] MODE_ONECOUNT = 3'h4;
	localparam logic [2:0] MODE_CAPONE   = 3'h6;

	// input edge codes
	localparam logic [1:0] EDGE_FALL      = 2'h0;
	localparam logic [1:0] EDGE_RISE      = 2'h1;
	localparam logic [1:0] EDGE_BOTH_LOW  = 2'h2;
	localparam logic [1:0] EDGE_BOTH_HIGH = 2'h3;

	typedef enum logic {
		CH_IDLE,
		CH_RUN
	} tcmpc_state_t;

endpackage

// >>> hdl/tcmpc_prescaler.sv
// prescaler giving two divided tick enables
// assumes the field values come from the prescaler select register
`timescale 1ns/100ps
module tcmpc_prescaler (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// division fields
	input  wire logic [3:0] sel_a_i,
	input  wire logic [3:0] sel_b_i,
	// tick enables
	output logic            tick_a_o,
	output logic            tick_b_o
);

	logic [14:0] div_ff;
	logic [14:0] mask_a;
	logic [14:0] mask_b;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_ff <= 15'h0000;
		end else begin
			div_ff <= div_ff + 15'h0001;
		end
	end

	// divide by two to the field
	assign mask_a   = 15'((16'h0001 << sel_a_i) - 16'h0001);
	assign mask_b   = 15'((16'h0001 << sel_b_i) - 16'h0001);
	assign tick_a_o = ((div_ff & mask_a) == mask_a);
	assign tick_b_o = ((div_ff & mask_b) == mask_b);

endmodule

// >>> hdl/tcmpc_top.sv
// master channel 0, configurable channel 1 and channel 2 mode register
// assumes an 8-bit register port and a pin synchronous to clk_i
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module tcmpc_top (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// register port
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	// channel pin
	input  wire logic       channel_input_pin_i,
	// events and outputs
	output logic            master_count_irq_o,
	output logic            ch1_irq_o,
	output logic            ch0_out_o,
	output logic            ch1_out_o,
	output logic            ch2_master_o
);

	logic [7:0]  prescaler_select_ff;
	logic [15:0] period_data_ff;
	logic [15:0] duty_data_ff;
	logic [7:0]  ch1_mode_high_ff;
	logic [7:0]  ch1_mode_low_ff;
	logic [7:0]  ch2_mode_high_ff;
	logic [7:0]  ch2_mode_low_ff;
	logic [7:0]  rdata_ff;

	logic tick_a;
	logic tick_b;
	logic op_tick;
	logic pin_rise;
	logic pin_fall;
	logic valid_edge;
	logic start_edge;
	logic capture_edge;
	logic count_tick;

	logic ctl_wr;
	logic sw_start0;
	logic sw_stop0;
	logic sw_start1;
	logic sw_stop1;

	logic [2:0] trigger_source_field;
	logic [1:0] input_edge_field;
	logic [2:0] op_mode_field;
	logic       start_behavior_bit;
	logic       width_split;

	assign trigger_source_field = ch1_mode_high_ff[2:0];
	assign input_edge_field     = ch1_mode_low_ff[7:6];
	assign op_mode_field        = ch1_mode_low_ff[3:1];
	assign start_behavior_bit   = ch1_mode_low_ff[tcmpc_pkg::POS_START_BEHAVIOR];
	assign width_split          = ch1_mode_high_ff[tcmpc_pkg::POS_WIDTH_SPLIT];

	assign ctl_wr    = wr_i && (addr_i == tcmpc_pkg::OFS_CONTROL);
	assign sw_start0 = ctl_wr && wdata_i[tcmpc_pkg::POS_CTL_CH0_START];
	assign sw_stop0  = ctl_wr && wdata_i[tcmpc_pkg::POS_CTL_CH0_STOP];
	assign sw_start1 = ctl_wr && wdata_i[tcmpc_pkg::POS_CTL_CH1_START];
	assign sw_stop1  = ctl_wr && wdata_i[tcmpc_pkg::POS_CTL_CH1_STOP];

	// clock generation
	tcmpc_prescaler u_prescaler (
		.clk_i    (clk_i),
		.rst_n_i  (rst_n_i),
		.sel_a_i  (prescaler_select_ff[3:0]),
		.sel_b_i  (prescaler_select_ff[7:4]),
		.tick_a_o (tick_a),
		.tick_b_o (tick_b)
	);

	assign op_tick = ch1_mode_high_ff[tcmpc_pkg::POS_OP_CLOCK_SELECT] ? tick_b : tick_a;

	tcmpc_edge_det u_edge_det (
		.clk_i    (clk_i),
		.rst_n_i  (rst_n_i),
		.sample_i (op_tick),
		.pin_i    (channel_input_pin_i),
		.rise_o   (pin_rise),
		.fall_o   (pin_fall)
	);

	always_comb begin
		case (input_edge_field)
			tcmpc_pkg::EDGE_FALL: begin
				valid_edge   = pin_fall;
				start_edge   = pin_fall;
				capture_edge = pin_fall;
			end
			tcmpc_pkg::EDGE_RISE: begin
				valid_edge   = pin_rise;
				start_edge   = pin_rise;
				capture_edge = pin_rise;
			end
			tcmpc_pkg::EDGE_BOTH_LOW: begin
				valid_edge   = pin_rise | pin_fall;
				start_edge   = pin_fall;
				capture_edge = pin_rise;
			end
			default: begin
				valid_edge   = pin_rise | pin_fall;
				start_edge   = pin_rise;
				capture_edge = pin_fall;
			end
		endcase
	end

	assign count_tick = ch1_mode_high_ff[tcmpc_pkg::POS_COUNT_CLOCK_SELECT] ? valid_edge
	                                                                        : op_tick;

	// master channel 0
	logic        m_run_ff;
	logic [15:0] m_cnt_ff;
	logic        m_irq_ff;
	logic        m_out_ff;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			m_run_ff <= 1'b0;
			m_cnt_ff <= tcmpc_pkg::RST_DATA;
		end else if (sw_stop0) begin
			m_run_ff <= 1'b0;
		end else if (sw_start0) begin
			m_run_ff <= 1'b1;
			m_cnt_ff <= period_data_ff;
		end else if (m_run_ff && op_tick) begin
			m_cnt_ff <= (m_cnt_ff == 16'h0000) ? period_data_ff : m_cnt_ff - 16'h0001;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			m_irq_ff <= 1'b0;
			m_out_ff <= 1'b0;
		end else begin
			m_irq_ff <= m_run_ff && !sw_stop0 && !sw_start0 && op_tick
			            && (m_cnt_ff == 16'h0000);
			if (m_run_ff && !sw_stop0 && !sw_start0 && op_tick && (m_cnt_ff == 16'h0000)) begin
				m_out_ff <= ~m_out_ff;
			end
		end
	end

	// channel 1 trigger selection
	logic start_trig;
	logic capture_trig;

	always_comb begin
		start_trig   = sw_start1;
		capture_trig = 1'b0;
		case (trigger_source_field)
			tcmpc_pkg::TRG_SOFTWARE: begin
				start_trig = sw_start1;
			end
			tcmpc_pkg::TRG_PIN_EDGE: begin
				start_trig   = sw_start1 | valid_edge;
				capture_trig = valid_edge;
			end
			tcmpc_pkg::TRG_BOTH_EDGES: begin
				start_trig   = sw_start1 | start_edge;
				capture_trig = capture_edge;
			end
			tcmpc_pkg::TRG_MASTER_PWM: begin
				start_trig = sw_start1
				             | (m_irq_ff && (op_mode_field == tcmpc_pkg::MODE_ONECOUNT));
			end
			tcmpc_pkg::TRG_MASTER_TWO: begin
				start_trig   = sw_start1
				               | (m_irq_ff && (op_mode_field == tcmpc_pkg::MODE_CAPTURE));
				capture_trig = valid_edge;
			end
			default: begin
				start_trig = sw_start1;
			end
		endcase
	end

	// channel 1 counting
	tcmpc_pkg::tcmpc_state_t state_ff;
	tcmpc_pkg::tcmpc_state_t nxt_state;
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic        out_ff;
	logic        nxt_out;
	logic        irq_ff;
	logic        nxt_irq;
	logic        cap_we;
	logic [15:0] load_val;
	logic [15:0] dec_val;
	logic        cnt_zero;

	assign load_val = width_split ? {8'h00, duty_data_ff[7:0]} : duty_data_ff;
	assign cnt_zero = width_split ? (cnt_ff[7:0] == 8'h00) : (cnt_ff == 16'h0000);
	assign dec_val  = cnt_ff - 16'h0001;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_out   = out_ff;
		nxt_irq   = 1'b0;
		cap_we    = 1'b0;
		case (state_ff)
			tcmpc_pkg::CH_IDLE: begin
				if (start_trig) begin
					nxt_state = tcmpc_pkg::CH_RUN;
					case (op_mode_field)
						tcmpc_pkg::MODE_INTERVAL, tcmpc_pkg::MODE_EVENT: begin
							nxt_cnt = load_val;
							if (start_behavior_bit) begin
								nxt_irq = 1'b1;
								nxt_out = ~out_ff;
							end
						end
						tcmpc_pkg::MODE_CAPTURE: begin
							nxt_cnt = 16'h0000;
							if (start_behavior_bit) begin
								nxt_irq = 1'b1;
								nxt_out = ~out_ff;
							end
						end
						tcmpc_pkg::MODE_ONECOUNT: begin
							nxt_cnt = load_val;
							nxt_out = (load_val != 16'h0000);
						end
						tcmpc_pkg::MODE_CAPONE: begin
							nxt_cnt = 16'h0000;
						end
						default: begin
							nxt_state = tcmpc_pkg::CH_IDLE;
						end
					endcase
				end
			end
			tcmpc_pkg::CH_RUN: begin
				case (op_mode_field)
					// count clock steps counter and output
					tcmpc_pkg::MODE_INTERVAL, tcmpc_pkg::MODE_EVENT: begin
						if (count_tick) begin
							nxt_cnt = cnt_zero ? load_val : dec_val;
							nxt_irq = cnt_zero;
							nxt_out = cnt_zero ? ~out_ff : out_ff;
						end
					end
					tcmpc_pkg::MODE_CAPTURE: begin
						if (capture_trig) begin
							cap_we  = 1'b1;
							nxt_irq = 1'b1;
							nxt_cnt = 16'h0000;
						end else if (count_tick) begin
							nxt_cnt = cnt_ff + 16'h0001;
						end
					end
					tcmpc_pkg::MODE_ONECOUNT: begin
						if (start_trig && start_behavior_bit) begin
							nxt_cnt = load_val;
							nxt_out = (load_val != 16'h0000);
						end else if (count_tick) begin
							if (cnt_zero || (dec_val == 16'h0000)
							    || (width_split && (dec_val[7:0] == 8'h00))) begin
								nxt_cnt   = 16'h0000;
								nxt_out   = 1'b0;
								nxt_irq   = 1'b1;
								nxt_state = tcmpc_pkg::CH_IDLE;
							end else begin
								nxt_cnt = dec_val;
							end
						end
					end
					tcmpc_pkg::MODE_CAPONE: begin
						if (capture_trig) begin
							cap_we    = 1'b1;
							nxt_irq   = 1'b1;
							nxt_state = tcmpc_pkg::CH_IDLE;
						end else if (count_tick) begin
							nxt_cnt = cnt_ff + 16'h0001;
						end
					end
					default: begin
						nxt_state = tcmpc_pkg::CH_IDLE;
					end
				endcase
			end
			default: begin
				nxt_state = tcmpc_pkg::CH_IDLE;
			end
		endcase
		if (sw_stop1) begin
			nxt_state = tcmpc_pkg::CH_IDLE;
			nxt_irq   = 1'b0;
			cap_we    = 1'b0;
		end
		if (width_split) begin
			nxt_cnt[15:8] = 8'h00;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= tcmpc_pkg::CH_IDLE;
			cnt_ff   <= tcmpc_pkg::RST_DATA;
			out_ff   <= 1'b0;
			irq_ff   <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			out_ff   <= nxt_out;
			irq_ff   <= nxt_irq;
		end
	end

	// register writes
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prescaler_select_ff <= tcmpc_pkg::RST_PRESCALER;
			period_data_ff      <= tcmpc_pkg::RST_DATA;
			ch1_mode_high_ff    <= tcmpc_pkg::RST_MODE;
			ch1_mode_low_ff     <= tcmpc_pkg::RST_MODE;
			ch2_mode_high_ff    <= tcmpc_pkg::RST_MODE;
			ch2_mode_low_ff     <= tcmpc_pkg::RST_MODE;
		end else if (wr_i) begin
			case (addr_i)
				tcmpc_pkg::OFS_PRESCALER_SELECT: prescaler_select_ff  <= wdata_i;
				tcmpc_pkg::OFS_CH0_DATA_LOW:     period_data_ff[7:0]  <= wdata_i;
				tcmpc_pkg::OFS_CH0_DATA_HIGH:    period_data_ff[15:8] <= wdata_i;
				tcmpc_pkg::OFS_CH1_MODE_LOW: begin
					ch1_mode_low_ff <= wdata_i & tcmpc_pkg::MASK_MODE_LOW;
				end
				tcmpc_pkg::OFS_CH1_MODE_HIGH: begin
					ch1_mode_high_ff <= wdata_i & tcmpc_pkg::MASK_MODE_HIGH;
				end
				tcmpc_pkg::OFS_CH2_MODE_LOW: begin
					ch2_mode_low_ff <= wdata_i & tcmpc_pkg::MASK_MODE_LOW;
				end
				tcmpc_pkg::OFS_CH2_MODE_HIGH: begin
					ch2_mode_high_ff <= wdata_i & tcmpc_pkg::MASK_MODE_HIGH;
				end
				default: begin
				end
			endcase
		end
	end

	// channel 1 data, capture wins over a bus write
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			duty_data_ff <= tcmpc_pkg::RST_DATA;
		end else if (cap_we) begin
			duty_data_ff <= cnt_ff;
		end else if (wr_i && (addr_i == tcmpc_pkg::OFS_CH1_DATA_LOW)) begin
			duty_data_ff[7:0] <= wdata_i;
		end else if (wr_i && (addr_i == tcmpc_pkg::OFS_CH1_DATA_HIGH)) begin
			duty_data_ff[15:8] <= wdata_i;
		end
	end

	// register reads, one cycle later
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_ff <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				tcmpc_pkg::OFS_PRESCALER_SELECT: rdata_ff <= prescaler_select_ff;
				tcmpc_pkg::OFS_CH0_DATA_LOW:     rdata_ff <= period_data_ff[7:0];
				tcmpc_pkg::OFS_CH0_DATA_HIGH:    rdata_ff <= period_data_ff[15:8];
				tcmpc_pkg::OFS_CH1_DATA_LOW:     rdata_ff <= duty_data_ff[7:0];
				tcmpc_pkg::OFS_CH1_DATA_HIGH:    rdata_ff <= duty_data_ff[15:8];
				tcmpc_pkg::OFS_CH1_MODE_LOW:     rdata_ff <= ch1_mode_low_ff;
				tcmpc_pkg::OFS_CH1_MODE_HIGH:    rdata_ff <= ch1_mode_high_ff;
				tcmpc_pkg::OFS_CH2_MODE_LOW:     rdata_ff <= ch2_mode_low_ff;
				tcmpc_pkg::OFS_CH2_MODE_HIGH:    rdata_ff <= ch2_mode_high_ff;
				tcmpc_pkg::OFS_STATUS: begin
					rdata_ff <= {4'h0, m_out_ff, out_ff,
					             (state_ff == tcmpc_pkg::CH_RUN), m_run_ff};
				end
				tcmpc_pkg::OFS_CH1_COUNT_LOW:    rdata_ff <= cnt_ff[7:0];
				tcmpc_pkg::OFS_CH1_COUNT_HIGH:   rdata_ff <= cnt_ff[15:8];
				default:                         rdata_ff <= 8'h00;
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign rdata_o            = rdata_ff;
	assign master_count_irq_o = m_irq_ff;
	assign ch1_irq_o          = irq_ff;
	assign ch0_out_o          = m_out_ff;
	assign ch1_out_o          = out_ff;
	assign ch2_master_o       = ch2_mode_high_ff[tcmpc_pkg::POS_MASTER_SELECT];

endmodule

// >>> tb/tb.sv
// self-checking bench for the timer channel mode block
// assumes tcmpc_top and tcmpc_checker are compiled before this file
`timescale 1ns/100ps
module tb;
	logic       clk_i   = 1'b0;
	logic       rst_n_i = 1'b0;
	logic [3:0] addr_i  = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i    = 1'b0;
	logic       rd_i    = 1'b0;
	logic       pin     = 1'b0;
	logic [7:0] rdata_o;
	logic       mirq;
	logic       c1irq;
	logic       c0out;
	logic       c1out;
	logic       c2m;
	logic [7:0] rv;
	logic [7:0] c1;
	logic [7:0] c2;
	logic       h0;
	logic [2:0] md_tab [0:4] = '{tcmpc_pkg::MODE_INTERVAL, tcmpc_pkg::MODE_CAPTURE,
		tcmpc_pkg::MODE_ONECOUNT, tcmpc_pkg::MODE_CAPONE, 3'h1};
	int         fails = 0;
	int         n_compared = 0;
	int         cyc = 0;
	int         k;
	int         g;
	int         h;

	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) cyc <= cyc + 1;

	tcmpc_top dut (
		.clk_i               (clk_i),
		.rst_n_i             (rst_n_i),
		.addr_i              (addr_i),
		.wdata_i             (wdata_i),
		.wr_i                (wr_i),
		.rd_i                (rd_i),
		.rdata_o             (rdata_o),
		.channel_input_pin_i (pin),
		.master_count_irq_o  (mirq),
		.ch1_irq_o           (c1irq),
		.ch0_out_o           (c0out),
		.ch1_out_o           (c1out),
		.ch2_master_o        (c2m)
	);

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1 d = rdata_o;
	endtask

	task automatic setpin(input logic v);
		@(posedge clk_i);
		pin <= v;
	endtask

	task automatic wait_irq(output int at);
		int i;
		for (i = 0; i < 400; i++) begin
			@(posedge clk_i);
			#1;
			if (mirq === 1'b1) break;
		end
		if (i == 400) begin
			fails++;
			$display("CHECK FAILED master irq expected pulse seen none");
			test_done();
		end
		at = cyc;
	endtask

	task automatic gap(output int d);
		int a;
		int b;
		wait_irq(a);
		wait_irq(b);
		d = b - a;
	endtask

	// count channel 1 output high cycles and interrupt pulses
	task automatic sample(input int n, output int hi, output int irqs);
		hi = 0;
		irqs = 0;
		repeat (n) begin
			#1;
			hi += (c1out === 1'b1);
			irqs += (c1irq === 1'b1);
			@(posedge clk_i);
		end
	endtask

	initial begin
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// reset values and unmapped reads
		for (k = 0; k < 16; k++) begin
			if (k != 9) begin
				rd(k[3:0], rv);
				check("reset read", rv, 8'h00);
			end
		end
		wr(4'h6, 8'hff);
		rd(4'h6, rv);
		check("ch1 mode high", rv, tcmpc_pkg::MASK_MODE_HIGH);
		wr(4'h5, 8'hff);
		rd(4'h5, rv);
		check("ch1 mode low", rv, tcmpc_pkg::MASK_MODE_LOW);
		wr(4'h8, 8'hff);
		#1 check("ch2 master", {7'h00, c2m}, 8'h01);
		wr(4'h8, 8'h00);
		#1 check("ch2 master", {7'h00, c2m}, 8'h00);
		wr(4'h6, 8'h00);
		wr(4'h5, 8'h00);
		for (k = 1; k < 5; k++) begin
			wr(k[3:0], 8'h5a ^ k[7:0]);
			rd(k[3:0], rv);
			check("data byte", rv, 8'h5a ^ k[7:0]);
		end
		// master period, prescaler and operation clock select
		wr(4'h1, 8'h03);
		wr(4'h2, 8'h00);
		wr(4'h0, 8'h00);
		wr(4'h9, 8'h01);
		gap(g);
		check("period 3", g[7:0], 8'h04);
		h0 = c0out;
		wait_irq(g);
		check("ch0 toggle", {7'h00, c0out}, {7'h00, ~h0});
		wr(4'h1, 8'h01);
		wr(4'h0, 8'h02);
		gap(g);
		gap(g);
		check("clock a div 4", g[7:0], 8'h08);
		wr(4'h0, 8'h12);
		wr(4'h6, 8'h80);
		gap(g);
		gap(g);
		check("clock b div 2", g[7:0], 8'h04);
		wr(4'h6, 8'h00);
		wr(4'h0, 8'h00);
		wr(4'h1, 8'h03);
		// pwm slave restarted by master, duty equals slave data
		for (k = 1; k < 4; k++) begin
			wr(4'h3, k[7:0]);
			wr(4'h4, 8'h00);
			wr(4'h5, 8'h08);
			wr(4'h6, 8'h04);
			wait_irq(g);
			wait_irq(g);
			sample(4, h, g);
			check("pwm high cycles", h[7:0], k[7:0]);
		end
		// software trigger only ignores the master interrupt
		wr(4'h6, 8'h00);
		wr(4'h9, 8'h08);
		gap(g);
		rd(4'ha, rv);
		check("sw only idle", {7'h00, rv[1]}, 8'h00);
		wr(4'h9, 8'h02);
		// count direction per mode, prohibited code stays idle
		wr(4'h3, 8'h40);
		for (k = 0; k < 5; k++) begin
			wr(4'h9, 8'h08);
			wr(4'h5, {4'h0, md_tab[k], 1'b0});
			wr(4'h9, 8'h04);
			rd(4'hb, c1);
			rd(4'hb, c2);
			rd(4'ha, rv);
			if (k < 4) begin
				check("count step", {7'h00, (k % 2 == 1) ? c2 > c1 : c1 > c2}, 8'h01);
				check("running", {7'h00, rv[1]}, 8'h01);
			end else begin
				check("prohibited idle", {7'h00, rv[1]}, 8'h00);
			end
		end
		// interrupt and output toggle at count start
		for (k = 0; k < 2; k++) begin
			wr(4'h9, 8'h08);
			wr(4'h5, {7'h00, k[0]});
			#1 h0 = c1out;
			wr(4'h9, 8'h04);
			sample(4, h, g);
			check("start irq", g[7:0], k[7:0]);
			#1 check("start toggle", {7'h00, c1out}, {7'h00, h0 ^ k[0]});
		end
		// pin edge start and capture, falling then rising edge
		for (k = 0; k < 2; k++) begin
			wr(4'h9, 8'h08);
			wr(4'h6, 8'h00);
			wr(4'h5, {k[1:0], 6'h04});
			setpin(k[0]);
			repeat (3) @(posedge clk_i);
			wr(4'h6, 8'h01);
			setpin(~k[0]);
			repeat (4) @(posedge clk_i);
			rd(4'ha, rv);
			check("wrong edge idle", {7'h00, rv[1]}, 8'h00);
			setpin(k[0]);
			repeat (4) @(posedge clk_i);
			rd(4'ha, rv);
			check("edge start", {7'h00, rv[1]}, 8'h01);
			setpin(~k[0]);
			repeat (4) @(posedge clk_i);
			setpin(k[0]);
			sample(6, h, g);
			check("capture irq", g[7:0], 8'h01);
			rd(4'h3, rv);
			check("captured count", {7'h00, rv != 8'h00 && rv < 8'h40}, 8'h01);
		end
		wr(4'h9, 8'h0a);
		test_done();
	end
endmodule

bind tcmpc_top tcmpc_checker u_chk (
	.clk_i               (clk_i),
	.rst_n_i             (rst_n_i),
	.addr_i              (addr_i),
	.wdata_i             (wdata_i),
	.wr_i                (wr_i),
	.rd_i                (rd_i),
	.rdata_o             (rdata_o),
	.channel_input_pin_i (channel_input_pin_i),
	.master_count_irq_o  (master_count_irq_o),
	.ch1_irq_o           (ch1_irq_o),
	.ch0_out_o           (ch0_out_o),
	.ch1_out_o           (ch1_out_o),
	.ch2_master_o        (ch2_master_o)
);

// >>> tb/tcmpc_properties.sv
// port-level assertions for the timer channel block
// assumes a bind onto tcmpc_top; channel 1 mode and the data registers are shadowed from bus writes
`timescale 1ns/100ps
module tcmpc_checker (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	// register port
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic [7:0] rdata_o,
	// pin and events
	input  wire logic       channel_input_pin_i,
	input  wire logic       master_count_irq_o,
	input  wire logic       ch1_irq_o,
	input  wire logic       ch0_out_o,
	input  wire logic       ch1_out_o,
	input  wire logic       ch2_master_o
);
	localparam logic [7:0] RSV_H = ~tcmpc_pkg::MASK_MODE_HIGH;
	localparam logic [7:0] RSV_L = ~tcmpc_pkg::MASK_MODE_LOW;
	logic [7:0]  mh_ff;
	logic [7:0]  ml_ff;
	logic [15:0] d0_ff;
	logic [15:0] d1_ff;
	logic        live_ff;
	logic        ctl_wr;
	logic        c2_wr;
	logic        ms_bit;
	logic        rd_mh;
	logic        rd_ml;
	logic        rd_unm;
	logic        wr_d0;
	logic        rd_d0;
	logic        sw_start;
	logic        slave_cfg;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	assign ctl_wr    = wr_i && addr_i == tcmpc_pkg::OFS_CONTROL;
	assign c2_wr     = wr_i && addr_i == tcmpc_pkg::OFS_CH2_MODE_HIGH;
	assign ms_bit    = wdata_i[tcmpc_pkg::POS_MASTER_SELECT];
	assign rd_mh     = rd_i && addr_i == tcmpc_pkg::OFS_CH1_MODE_HIGH;
	assign rd_ml     = rd_i && addr_i == tcmpc_pkg::OFS_CH1_MODE_LOW;
	assign rd_unm    = rd_i && addr_i > tcmpc_pkg::OFS_CH1_COUNT_HIGH;
	assign wr_d0     = wr_i && addr_i == tcmpc_pkg::OFS_CH0_DATA_LOW;
	assign rd_d0     = rd_i && addr_i == tcmpc_pkg::OFS_CH0_DATA_LOW;
	assign sw_start  = ctl_wr && wdata_i[2] && !wdata_i[3] && !live_ff && !mh_ff[3]
		&& mh_ff[2:0] == tcmpc_pkg::TRG_SOFTWARE && ml_ff[3:1] == tcmpc_pkg::MODE_INTERVAL;
	assign slave_cfg = ml_ff[3:1] == tcmpc_pkg::MODE_ONECOUNT && !mh_ff[3] && !mh_ff[4]
		&& mh_ff[2:0] == tcmpc_pkg::TRG_MASTER_PWM && d1_ff != 16'h0000;

	// shadow of the configuration written by software
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mh_ff <= 8'h00;
			ml_ff <= 8'h00;
			d0_ff <= 16'h0000;
			d1_ff <= 16'h0000;
		end else if (wr_i) begin
			case (addr_i)
				tcmpc_pkg::OFS_CH1_MODE_HIGH: mh_ff <= wdata_i;
				tcmpc_pkg::OFS_CH1_MODE_LOW:  ml_ff <= wdata_i;
				tcmpc_pkg::OFS_CH0_DATA_LOW:  d0_ff[7:0] <= wdata_i;
				tcmpc_pkg::OFS_CH0_DATA_HIGH: d0_ff[15:8] <= wdata_i;
				tcmpc_pkg::OFS_CH1_DATA_LOW:  d1_ff[7:0] <= wdata_i;
				tcmpc_pkg::OFS_CH1_DATA_HIGH: d1_ff[15:8] <= wdata_i;
				default: ;
			endcase
		end
	end

	// channel 1 started by software and not stopped since
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			live_ff <= 1'b0;
		end else if (ctl_wr) begin
			live_ff <= wdata_i[3] ? 1'b0 : (wdata_i[2] | live_ff);
		end
	end

	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not zero outside read cycle");
	a_mode_high_rsvd: assert property ($past(rd_mh) |-> (rdata_o & RSV_H) == 8'h00)
		else $error("reserved mode high bits read nonzero");
	a_mode_low_rsvd: assert property ($past(rd_ml) |-> (rdata_o & RSV_L) == 8'h00)
		else $error("reserved mode low bits read nonzero");
	a_unmapped_zero: assert property ($past(rd_unm) |-> rdata_o == 8'h00)
		else $error("unmapped read nonzero");
	a_period_readback: assert property (wr_d0 ##1 !wr_i ##1 rd_d0
		|=> rdata_o == $past(wdata_i, 3))
		else $error("period data readback mismatch");
	a_master_select: assert property ($past(c2_wr) |-> ch2_master_o == $past(ms_bit))
		else $error("master select output wrong");
	a_irq_one_wide: assert property (master_count_irq_o && d0_ff != 16'h0000
		|=> !master_count_irq_o)
		else $error("master interrupt wider than one cycle");
	a_slave_restart: assert property (master_count_irq_o && slave_cfg |-> ##[1:3] ch1_out_o)
		else $error("slave not restarted by master interrupt");
	a_start_irq: assert property (sw_start && ml_ff[0] |-> ##[1:3] ch1_irq_o)
		else $error("no interrupt at count start");
	a_start_quiet: assert property (sw_start && !ml_ff[0] && d1_ff >= 16'h0008
		|=> !ch1_irq_o [*4])
		else $error("interrupt at count start while disabled");

	a_ch0_toggle: assert property ($changed(ch0_out_o) |-> master_count_irq_o)
		else $error("ch0 out changed off period end");
	c_master_irq: cover property (master_count_irq_o);
	c_slave_run: cover property (master_count_irq_o && slave_cfg);
	c_start_irq: cover property (sw_start && ml_ff[0]);
endmodule
